// File: lio_consts.svh
// Address windows, offsets, implemented-bit masks and reset value of the low I/O register space
`ifndef LIO_CONSTS_SVH
`define LIO_CONSTS_SVH

// ----------------------------------------------------------------------
// Address windows
// ----------------------------------------------------------------------
`define LIO_IO_LAST 8'h3f
`define LIO_BIT_LAST 8'h1f
`define LIO_DATA_OFFSET 8'h20
`define LIO_EXT_FIRST 8'h60

// ----------------------------------------------------------------------
// Register offsets in I/O space
// ----------------------------------------------------------------------
`define LIO_PORT_B_PIN_INPUT 5'h03
`define LIO_PORT_B_DIRECTION 5'h04
`define LIO_PORT_B_OUTPUT_LATCH 5'h05
`define LIO_PORT_C_PIN_INPUT 5'h06
`define LIO_PORT_C_DIRECTION 5'h07
`define LIO_PORT_C_OUTPUT_LATCH 5'h08
`define LIO_PORT_D_PIN_INPUT 5'h09
`define LIO_PORT_D_DIRECTION 5'h0a
`define LIO_PORT_D_OUTPUT_LATCH 5'h0b
`define LIO_TIMER0_FLAGS 5'h15
`define LIO_TIMER1_FLAGS 5'h16
`define LIO_TIMER2_FLAGS 5'h17
`define LIO_PIN_CHANGE_FLAGS 5'h1b
`define LIO_EXTERNAL_IRQ_FLAGS 5'h1c
`define LIO_EXTERNAL_IRQ_MASK 5'h1d

// ----------------------------------------------------------------------
// Implemented-bit masks and reset value
// ----------------------------------------------------------------------
`define LIO_MASK_FULL 8'hff
`define LIO_MASK_PORT_C 8'h7f
`define LIO_MASK_TIMER0 8'h07
`define LIO_MASK_TIMER1 8'h27
`define LIO_MASK_TIMER2 8'h07
`define LIO_MASK_PIN_CHANGE 8'h07
`define LIO_MASK_EXT_IRQ 8'h03
`define LIO_RESET_VALUE 8'h00

`endif

// File: lio_pkg.sv
// Types shared by the low I/O register space design
package lio_pkg;

   // -------------------------------------------------------------------
   // Access kinds issued by the core
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      LIO_OP_NONE = 3'h0,
      LIO_OP_IO_READ = 3'h1,
      LIO_OP_IO_WRITE = 3'h2,
      LIO_OP_DATA_READ = 3'h3,
      LIO_OP_DATA_WRITE = 3'h4,
      LIO_OP_BIT_SET = 3'h5,
      LIO_OP_BIT_CLEAR = 3'h6,
      LIO_OP_BIT_TEST = 3'h7
   } lio_op_t;

   // -------------------------------------------------------------------
   // One core request
   // -------------------------------------------------------------------
   typedef struct packed {
      lio_op_t op;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [2:0] bit_sel;
   } lio_req_t;

   // -------------------------------------------------------------------
   // Answer to the core
   // -------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic bit_value;
      logic ext_sel;
   } lio_rsp_t;

   // -------------------------------------------------------------------
   // Peripheral flag set events, one bit per flag position
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] timer0;
      logic [7:0] timer1;
      logic [7:0] timer2;
      logic [7:0] pin_change;
      logic [7:0] ext_irq;
   } lio_flag_set_t;

endpackage : lio_pkg

// File: lio_sync.sv
// Two-stage synchroniser for a bus of asynchronous pin levels
`timescale 1ns/10ps
module lio_sync #(
   parameter int WIDTH = 8
) (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   // Hold state while the enable is low
   always_comb begin
      next_stage1 = stage1;
      next_sync_out = sync_out;
      if (clk_en) begin
         next_stage1 = async_in;
         next_sync_out = stage1;
      end
   end

   // Two flip-flops, first read only by the second
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule : lio_sync

// File: lio_flag_reg.sv
// One byte of sticky flags: hardware set, write-one-to-clear
`timescale 1ns/10ps
`include "lio_consts.svh"
module lio_flag_reg #(
   parameter logic [7:0] IMPL_MASK = 8'hff
) (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Events and clear
   input wire logic [7:0] set_evt,
   input wire logic [7:0] clear_bits,
   // State
   output logic [7:0] flags
);
   logic [7:0] next_flags;

   // Set wins over a clear in the same cycle; zeros leave flags alone
   always_comb begin
      next_flags = flags;
      if (clk_en) begin
         next_flags = ((flags & ~clear_bits) | set_evt) & IMPL_MASK;
      end
   end

   // Register the flags
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flags <= `LIO_RESET_VALUE;
      end else begin
         flags <= next_flags;
      end
   end
endmodule : lio_flag_reg

// File: lio_regs.sv
// Low I/O register space: decode, ports, flags and bit operations
`timescale 1ns/10ps
`include "lio_consts.svh"

module lio_regs (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Core request and answer
   input wire lio_pkg::lio_req_t req,
   output lio_pkg::lio_rsp_t rsp,
   // Peripheral flag events
   input wire lio_pkg::lio_flag_set_t flag_set,
   // Port pins, split into input, output and enable
   input wire logic [7:0] port_b_pin,
   input wire logic [7:0] port_c_pin,
   input wire logic [7:0] port_d_pin,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic [7:0] port_c_out,
   output logic [7:0] port_c_oe,
   output logic [7:0] port_d_out,
   output logic [7:0] port_d_oe,
   // Register state seen by peripherals
   output logic [7:0] external_irq_mask_out,
   output logic [7:0] timer0_flags_out,
   output logic [7:0] timer1_flags_out,
   output logic [7:0] timer2_flags_out,
   output logic [7:0] pin_change_flags_out,
   output logic [7:0] external_irq_flags_out
);
   import lio_pkg::*;

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------

   // One-hot byte for a bit position
   function automatic logic [7:0] bit_mask(input logic [2:0] pos);
      bit_mask = 8'h01 << pos;
   endfunction : bit_mask

   // Update of a read-write register: full write or single-bit change
   function automatic logic [7:0] rw_update(input logic [7:0] cur, input logic [7:0] wd,
                                            input logic [7:0] bm, input logic full_wr,
                                            input logic set_op, input logic clr_op,
                                            input logic [7:0] impl);
      logic [7:0] v;
      v = cur;
      if (full_wr) begin
         v = wd;
      end else if (set_op) begin
         v = cur | bm;
      end else if (clr_op) begin
         v = cur & ~bm;
      end
      rw_update = v & impl;
   endfunction : rw_update

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [7:0] pin_b_sync;
   logic [7:0] pin_c_sync;
   logic [7:0] pin_d_sync;

   lio_sync #(.WIDTH(8)) u_sync_b (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .async_in(port_b_pin), .sync_out(pin_b_sync)
   );
   lio_sync #(.WIDTH(8)) u_sync_c (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .async_in(port_c_pin), .sync_out(pin_c_sync)
   );
   lio_sync #(.WIDTH(8)) u_sync_d (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .async_in(port_d_pin), .sync_out(pin_d_sync)
   );

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   logic is_io_op;
   logic is_data_op;
   logic is_bit_op;
   logic io_hit;
   logic [7:0] data_io;
   logic data_hit;
   logic ext_hit;
   logic bit_hit;
   logic low_hit;
   logic [4:0] low_addr;
   logic full_wr;
   logic set_op;
   logic clr_op;
   logic [7:0] bm;
   logic [7:0] wr_value;

   // Classify the access and map both spaces onto one I/O offset
   always_comb begin
      is_io_op = (req.op == LIO_OP_IO_READ) || (req.op == LIO_OP_IO_WRITE);
      is_data_op = (req.op == LIO_OP_DATA_READ) || (req.op == LIO_OP_DATA_WRITE);
      is_bit_op = (req.op == LIO_OP_BIT_SET) || (req.op == LIO_OP_BIT_CLEAR)
                  || (req.op == LIO_OP_BIT_TEST);
      io_hit = is_io_op && (req.addr <= `LIO_IO_LAST);
      data_io = req.addr - `LIO_DATA_OFFSET;
      data_hit = is_data_op && (req.addr >= `LIO_DATA_OFFSET)
                 && (data_io <= `LIO_IO_LAST);
      ext_hit = is_data_op && (req.addr >= `LIO_EXT_FIRST);
      bit_hit = is_bit_op && (req.addr <= `LIO_BIT_LAST);
      low_hit = bit_hit || ((io_hit || data_hit)
                && ((io_hit ? req.addr : data_io) <= `LIO_BIT_LAST));
      low_addr = io_hit ? req.addr[4:0] : (data_hit ? data_io[4:0] : req.addr[4:0]);
      full_wr = (req.op == LIO_OP_IO_WRITE && io_hit)
                || (req.op == LIO_OP_DATA_WRITE && data_hit);
      set_op = (req.op == LIO_OP_BIT_SET) && bit_hit;
      clr_op = (req.op == LIO_OP_BIT_CLEAR) && bit_hit;
      bm = bit_mask(req.bit_sel);
      wr_value = req.wdata;
   end

   // ----------------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------------
   logic [7:0] port_b_direction;
   logic [7:0] port_b_output_latch;
   logic [7:0] port_c_direction;
   logic [7:0] port_c_output_latch;
   logic [7:0] port_d_direction;
   logic [7:0] port_d_output_latch;
   logic [7:0] next_port_b_direction;
   logic [7:0] next_port_b_output_latch;
   logic [7:0] next_port_c_direction;
   logic [7:0] next_port_c_output_latch;
   logic [7:0] next_port_d_direction;
   logic [7:0] next_port_d_output_latch;
   logic [7:0] external_irq_mask;
   logic [7:0] next_external_irq_mask;

   // Full writes or single-bit changes, only on the addressed register
   always_comb begin
      next_port_b_direction = port_b_direction;
      next_port_b_output_latch = port_b_output_latch;
      next_port_c_direction = port_c_direction;
      next_port_c_output_latch = port_c_output_latch;
      next_port_d_direction = port_d_direction;
      next_port_d_output_latch = port_d_output_latch;
      next_external_irq_mask = external_irq_mask;
      if (clk_en && low_hit) begin
         unique case (low_addr)
            `LIO_PORT_B_DIRECTION: begin
               next_port_b_direction = rw_update(port_b_direction, wr_value, bm,
                  full_wr, set_op, clr_op, `LIO_MASK_FULL);
            end
            `LIO_PORT_B_OUTPUT_LATCH: begin
               next_port_b_output_latch = rw_update(port_b_output_latch, wr_value, bm,
                  full_wr, set_op, clr_op, `LIO_MASK_FULL);
            end
            `LIO_PORT_C_DIRECTION: begin
               next_port_c_direction = rw_update(port_c_direction, wr_value, bm,
                  full_wr, set_op, clr_op, `LIO_MASK_PORT_C);
            end
            `LIO_PORT_C_OUTPUT_LATCH: begin
               next_port_c_output_latch = rw_update(port_c_output_latch, wr_value, bm,
                  full_wr, set_op, clr_op, `LIO_MASK_PORT_C);
            end
            `LIO_PORT_D_DIRECTION: begin
               next_port_d_direction = rw_update(port_d_direction, wr_value, bm,
                  full_wr, set_op, clr_op, `LIO_MASK_FULL);
            end
            `LIO_PORT_D_OUTPUT_LATCH: begin
               next_port_d_output_latch = rw_update(port_d_output_latch, wr_value, bm,
                  full_wr, set_op, clr_op, `LIO_MASK_FULL);
            end
            `LIO_EXTERNAL_IRQ_MASK: begin
               next_external_irq_mask = rw_update(external_irq_mask, wr_value, bm,
                  full_wr, set_op, clr_op, `LIO_MASK_EXT_IRQ);
            end
            default: begin
               // Reserved and read-only locations ignore writes
               next_external_irq_mask = external_irq_mask;
            end
         endcase
      end
   end

   // Register the port and mask state
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         port_b_direction <= `LIO_RESET_VALUE;
         port_b_output_latch <= `LIO_RESET_VALUE;
         port_c_direction <= `LIO_RESET_VALUE;
         port_c_output_latch <= `LIO_RESET_VALUE;
         port_d_direction <= `LIO_RESET_VALUE;
         port_d_output_latch <= `LIO_RESET_VALUE;
         external_irq_mask <= `LIO_RESET_VALUE;
      end else begin
         port_b_direction <= next_port_b_direction;
         port_b_output_latch <= next_port_b_output_latch;
         port_c_direction <= next_port_c_direction;
         port_c_output_latch <= next_port_c_output_latch;
         port_d_direction <= next_port_d_direction;
         port_d_output_latch <= next_port_d_output_latch;
         external_irq_mask <= next_external_irq_mask;
      end
   end

   // Pin drivers straight from the registers
   assign port_b_out = port_b_output_latch;
   assign port_b_oe = port_b_direction;
   assign port_c_out = port_c_output_latch;
   assign port_c_oe = port_c_direction;
   assign port_d_out = port_d_output_latch;
   assign port_d_oe = port_d_direction;
   assign external_irq_mask_out = external_irq_mask;

   // ----------------------------------------------------------------------
   // Flag registers
   // ----------------------------------------------------------------------
   logic [7:0] clr_t0;
   logic [7:0] clr_t1;
   logic [7:0] clr_t2;
   logic [7:0] clr_pc;
   logic [7:0] clr_ei;
   logic [7:0] flag_clear;

   // Clear bits: a full write clears its ones, a bit set clears only its bit
   always_comb begin
      flag_clear = 8'h00;
      if (full_wr) begin
         flag_clear = wr_value;
      end else if (set_op) begin
         flag_clear = bm;
      end
      clr_t0 = (low_hit && low_addr == `LIO_TIMER0_FLAGS) ? flag_clear : 8'h00;
      clr_t1 = (low_hit && low_addr == `LIO_TIMER1_FLAGS) ? flag_clear : 8'h00;
      clr_t2 = (low_hit && low_addr == `LIO_TIMER2_FLAGS) ? flag_clear : 8'h00;
      clr_pc = (low_hit && low_addr == `LIO_PIN_CHANGE_FLAGS) ? flag_clear : 8'h00;
      clr_ei = (low_hit && low_addr == `LIO_EXTERNAL_IRQ_FLAGS) ? flag_clear : 8'h00;
   end

   lio_flag_reg #(.IMPL_MASK(`LIO_MASK_TIMER0)) u_flag_t0 (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .set_evt(flag_set.timer0), .clear_bits(clr_t0), .flags(timer0_flags_out)
   );
   lio_flag_reg #(.IMPL_MASK(`LIO_MASK_TIMER1)) u_flag_t1 (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .set_evt(flag_set.timer1), .clear_bits(clr_t1), .flags(timer1_flags_out)
   );
   lio_flag_reg #(.IMPL_MASK(`LIO_MASK_TIMER2)) u_flag_t2 (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .set_evt(flag_set.timer2), .clear_bits(clr_t2), .flags(timer2_flags_out)
   );
   lio_flag_reg #(.IMPL_MASK(`LIO_MASK_PIN_CHANGE)) u_flag_pc (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .set_evt(flag_set.pin_change), .clear_bits(clr_pc), .flags(pin_change_flags_out)
   );
   lio_flag_reg #(.IMPL_MASK(`LIO_MASK_EXT_IRQ)) u_flag_ei (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .set_evt(flag_set.ext_irq), .clear_bits(clr_ei), .flags(external_irq_flags_out)
   );

   // ----------------------------------------------------------------------
   // Read mux and answer register
   // ----------------------------------------------------------------------
   logic [7:0] rd_byte;
   lio_rsp_t next_rsp;

   // Select the addressed byte; reserved locations read zero
   always_comb begin
      rd_byte = 8'h00;
      if (low_hit) begin
         unique case (low_addr)
            `LIO_PORT_B_PIN_INPUT: rd_byte = pin_b_sync;
            `LIO_PORT_B_DIRECTION: rd_byte = port_b_direction;
            `LIO_PORT_B_OUTPUT_LATCH: rd_byte = port_b_output_latch;
            `LIO_PORT_C_PIN_INPUT: rd_byte = pin_c_sync & `LIO_MASK_PORT_C;
            `LIO_PORT_C_DIRECTION: rd_byte = port_c_direction;
            `LIO_PORT_C_OUTPUT_LATCH: rd_byte = port_c_output_latch;
            `LIO_PORT_D_PIN_INPUT: rd_byte = pin_d_sync;
            `LIO_PORT_D_DIRECTION: rd_byte = port_d_direction;
            `LIO_PORT_D_OUTPUT_LATCH: rd_byte = port_d_output_latch;
            `LIO_TIMER0_FLAGS: rd_byte = timer0_flags_out;
            `LIO_TIMER1_FLAGS: rd_byte = timer1_flags_out;
            `LIO_TIMER2_FLAGS: rd_byte = timer2_flags_out;
            `LIO_PIN_CHANGE_FLAGS: rd_byte = pin_change_flags_out;
            `LIO_EXTERNAL_IRQ_FLAGS: rd_byte = external_irq_flags_out;
            `LIO_EXTERNAL_IRQ_MASK: rd_byte = external_irq_mask;
            default: rd_byte = 8'h00;
         endcase
      end
      next_rsp = rsp;
      if (clk_en) begin
         next_rsp.valid = (req.op != LIO_OP_NONE);
         next_rsp.rdata = rd_byte;
         next_rsp.bit_value = (req.op == LIO_OP_BIT_TEST) && bit_hit
                              && rd_byte[req.bit_sel];
         next_rsp.ext_sel = ext_hit;
      end
   end

   // Register the answer one cycle after the request
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end
endmodule : lio_regs

// File: lio_regs_properties.sv
// Concurrent checks on the low I/O register space ports
`timescale 1ns/10ps
module lio_regs_properties (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Core side
   input wire lio_pkg::lio_req_t req,
   input wire lio_pkg::lio_rsp_t rsp,
   input wire lio_pkg::lio_flag_set_t flag_set,
   // Register state
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_oe,
   input wire logic [7:0] port_d_out,
   input wire logic [7:0] timer0_flags_out,
   input wire logic [7:0] timer1_flags_out,
   input wire logic [7:0] external_irq_mask_out
);
   import lio_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // --------------------------------------------------------------
   // Requests taken at an enabled edge
   // --------------------------------------------------------------
   sequence s_op(lio_op_t o, logic [7:0] a);
      clk_en && req.op == o && req.addr == a;
   endsequence
   // --------------------------------------------------------------
   // Properties
   // --------------------------------------------------------------
   AST_VALID: assert property (clk_en && req.op != LIO_OP_NONE |=> rsp.valid)
      else $error("no answer to a request");
   AST_IDLE: assert property (clk_en && req.op == LIO_OP_NONE |=> !rsp.valid)
      else $error("answer without request");
   AST_LATCH_D: assert property (s_op(LIO_OP_IO_WRITE, 8'h0b) |=>
      port_d_out == $past(req.wdata)) else $error("port D latch missed write");
   AST_DATA_B: assert property (s_op(LIO_OP_DATA_WRITE, 8'h25) |=>
      port_b_out == $past(req.wdata)) else $error("port B data write missed");
   AST_BIT_SET: assert property (s_op(LIO_OP_BIT_SET, 8'h05) |=>
      port_b_out == ($past(port_b_out) | (8'h01 << $past(req.bit_sel))))
      else $error("bit set wrong");
   AST_W1C: assert property (s_op(LIO_OP_IO_WRITE, 8'h15) ##0 flag_set.timer0 == 8'h00 |=>
      timer0_flags_out == ($past(timer0_flags_out) & ~$past(req.wdata)))
      else $error("flag clear wrong");
   AST_PORT_C: assert property (port_c_out[7] == 1'b0 && port_c_oe[7] == 1'b0)
      else $error("port C bit 7 driven");
   AST_EXT: assert property (clk_en && req.op == LIO_OP_DATA_READ && req.addr >= 8'h60 |=>
      rsp.ext_sel && rsp.rdata == 8'h00) else $error("extended read wrong");
   AST_IO_HIGH: assert property (clk_en && req.op == LIO_OP_IO_READ && req.addr > 8'h3f |=>
      rsp.rdata == 8'h00 && !rsp.ext_sel) else $error("I/O read past range");
   AST_MASK: assert property ((timer1_flags_out & 8'hd8) == 8'h00 &&
      (external_irq_mask_out & 8'hfc) == 8'h00) else $error("unimplemented bit set");
endmodule : lio_regs_properties

bind lio_regs lio_regs_properties u_chk (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
   .req(req), .rsp(rsp), .flag_set(flag_set), .port_b_out(port_b_out),
   .port_c_out(port_c_out), .port_c_oe(port_c_oe), .port_d_out(port_d_out),
   .timer0_flags_out(timer0_flags_out), .timer1_flags_out(timer1_flags_out),
   .external_irq_mask_out(external_irq_mask_out));

// File: lio_core_model.sv
// Processor core model issuing one request at a time
`timescale 1ns/10ps
module lio_core_model (
   // Clock
   input wire logic mclk,
   // Request and answer
   output lio_pkg::lio_req_t req,
   input wire lio_pkg::lio_rsp_t rsp
);
   import lio_pkg::*;
   // Idle request with all data bits zero
   initial req = '0;
   // Hold a request for one edge, take the answer, then idle one edge
   // so that back-to-back calls never drive the request twice at once
   task automatic xfer(input lio_op_t o, input logic [7:0] a, input logic [7:0] w,
                       input logic [2:0] b, output lio_rsp_t r);
      req = '{o, a, w, b};
      @(posedge mclk);
      #1;
      r = rsp;
      req.op = LIO_OP_NONE;
      @(posedge mclk);
      #1;
   endtask : xfer
endmodule : lio_core_model

// File: low_io_register_space_tb.sv
// Self-checking bench for the low I/O register space
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module low_io_register_space_tb;
   import lio_pkg::*;
   logic mclk, rst_b, clk_en;
   lio_req_t req;
   lio_rsp_t rsp, r;
   lio_flag_set_t fs;
   logic [7:0] pb, pc, pd, bo, boe, co, coe, dout, doe, msk, f0, f1, f2, fpc, fex;
   int num_errors = 0;
   int cmp_count = 0;
   // --------------------------------------------------------------
   // Design, core model, clock
   // --------------------------------------------------------------
   lio_regs dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .req(req), .rsp(rsp),
      .flag_set(fs), .port_b_pin(pb), .port_c_pin(pc), .port_d_pin(pd),
      .port_b_out(bo), .port_b_oe(boe), .port_c_out(co), .port_c_oe(coe),
      .port_d_out(dout), .port_d_oe(doe), .external_irq_mask_out(msk),
      .timer0_flags_out(f0), .timer1_flags_out(f1), .timer2_flags_out(f2),
      .pin_change_flags_out(fpc), .external_irq_flags_out(fex));
   lio_core_model core (.mclk(mclk), .req(req), .rsp(rsp));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task automatic results;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic x(input lio_op_t o, input logic [7:0] a, w, input logic [2:0] b);
      core.xfer(o, a, w, b, r);
      `CHK(r.valid, 1'b1)
   endtask : x
   // Three ports through I/O and data space, pins and masks
   task automatic t_ports;
      logic [7:0] bs [3];
      logic [7:0] mk [3];
      bs = '{8'h03, 8'h06, 8'h09};
      mk = '{8'hff, 8'h7f, 8'hff};
      for (int i = 0; i < 3; i++) begin
         x(LIO_OP_IO_WRITE, bs[i] + 8'h02, 8'hff, 3'h0);
         x(LIO_OP_DATA_WRITE, bs[i] + 8'h21, 8'h96, 3'h0);
         x(LIO_OP_IO_WRITE, bs[i], 8'h55, 3'h0);
         x(LIO_OP_DATA_READ, bs[i] + 8'h22, 8'h00, 3'h0);
         `CHK(r.rdata, mk[i])
         x(LIO_OP_IO_READ, bs[i] + 8'h01, 8'h00, 3'h0);
         `CHK(r.rdata, 8'h96 & mk[i])
         x(LIO_OP_IO_READ, bs[i], 8'h00, 3'h0);
         `CHK(r.rdata, 8'hc3 & mk[i])
      end
      `CHK({bo, boe, co, coe, dout, doe}, 48'hff967f16ff96)
   endtask : t_ports
   // Single-bit set, clear and test
   task automatic t_bits;
      x(LIO_OP_IO_WRITE, 8'h05, 8'ha5, 3'h0);
      x(LIO_OP_BIT_SET, 8'h05, 8'h00, 3'h3);
      `CHK(bo, 8'had)
      x(LIO_OP_BIT_CLEAR, 8'h05, 8'h00, 3'h0);
      `CHK(bo, 8'hac)
      pd = 8'h04;
      repeat (2) @(posedge mclk);
      #1;
      x(LIO_OP_BIT_TEST, 8'h09, 8'h00, 3'h2);
      `CHK(r.bit_value, 1'b1)
      x(LIO_OP_BIT_TEST, 8'h09, 8'h00, 3'h3);
      `CHK(r.bit_value, 1'b0)
      x(LIO_OP_BIT_SET, 8'h25, 8'h00, 3'h0);
      `CHK(bo, 8'hac)
   endtask : t_bits
   // Sticky flags, write-one-to-clear, bit ops beside them
   task automatic t_flags;
      fs = '0;
      fs.timer0 = 8'h05;
      fs.timer1 = 8'hff;
      fs.timer2 = 8'hff;
      fs.pin_change = 8'hff;
      fs.ext_irq = 8'hff;
      @(posedge mclk);
      #1;
      fs = '0;
      `CHK({f0, f1, f2, fpc, fex}, 40'h0527070703)
      x(LIO_OP_IO_WRITE, 8'h15, 8'h01, 3'h0);
      `CHK(f0, 8'h04)
      x(LIO_OP_BIT_SET, 8'h16, 8'h00, 3'h0);
      `CHK(f1, 8'h26)
      x(LIO_OP_BIT_CLEAR, 8'h16, 8'h00, 3'h1);
      `CHK(f1, 8'h26)
      x(LIO_OP_IO_WRITE, 8'h16, 8'h04, 3'h0);
      `CHK(f1, 8'h22)
      x(LIO_OP_IO_WRITE, 8'h16, 8'h00, 3'h0);
      `CHK(f1, 8'h22)
      x(LIO_OP_BIT_TEST, 8'h16, 8'h00, 3'h5);
      `CHK(r.bit_value, 1'b1)
      x(LIO_OP_DATA_WRITE, 8'h3c, 8'h01, 3'h0);
      `CHK(fex, 8'h02)
      x(LIO_OP_IO_WRITE, 8'h17, 8'h02, 3'h0);
      `CHK(f2, 8'h05)
      x(LIO_OP_DATA_WRITE, 8'h3b, 8'h04, 3'h0);
      `CHK(fpc, 8'h03)
   endtask : t_flags
   // Address windows, reserved places, clock enable
   task automatic t_space;
      x(LIO_OP_IO_READ, 8'h40, 8'h00, 3'h0);
      `CHK(r.rdata, 8'h00)
      x(LIO_OP_DATA_READ, 8'h60, 8'h00, 3'h0);
      `CHK({r.ext_sel, r.rdata}, 9'h100)
      x(LIO_OP_DATA_WRITE, 8'hff, 8'h12, 3'h0);
      `CHK(r.ext_sel, 1'b1)
      x(LIO_OP_IO_WRITE, 8'h60, 8'h12, 3'h0);
      `CHK(r.ext_sel, 1'b0)
      x(LIO_OP_DATA_READ, 8'h0b, 8'h00, 3'h0);
      `CHK(r.rdata, 8'h00)
      x(LIO_OP_IO_READ, 8'h0c, 8'h00, 3'h0);
      `CHK(r.rdata, 8'h00)
      x(LIO_OP_IO_WRITE, 8'h1d, 8'hff, 3'h0);
      x(LIO_OP_DATA_READ, 8'h3d, 8'h00, 3'h0);
      `CHK({msk, r.rdata}, 16'h0303)
      clk_en = 1'b0;
      core.xfer(LIO_OP_IO_WRITE, 8'h0b, 8'h00, 3'h0, r);
      clk_en = 1'b1;
      `CHK(dout, 8'hff)
   endtask : t_space
   // --------------------------------------------------------------
   // Main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      fs = '0;
      pb = 8'hc3;
      pc = 8'hc3;
      pd = 8'hc3;
      repeat (10) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      `CHK({bo, boe, co, coe, dout, doe, msk, f0, f1}, 72'h0)
      t_ports;
      t_bits;
      t_flags;
      t_space;
      results;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      num_errors++;
      results;
   end
endmodule : low_io_register_space_tb
